/* design/stplm_top.sv */
// Purpose: Lane mapping, sync header choice, power-down and test patterns of the serial transmit path.
// Assumes: Samples arrive as 32 words per cycle; the pin input is asynchronous to sys_clk_i.
// Notes: Configuration registers are never cleared by power-down, only by rst_i.
`timescale 1ns/1ps
// Contract
// - Four-channel mode: pad, lane pair alternates samples.
// - Dual-channel mode: lane k carries k%4+16*(k/4), then every fourth sample.
// - Only CRC-12 offered, CRC-3 refused.
// - FEC may use sync header instead.
// - Pin high disables drivers, powers down.
// - Mode setting also forces full power-down.
// - Configuration survives power-down.
// - Channel pair enable never turns all off.
// - Test select; lanes still follow link mode.
// - PRBS bypasses transport, link, scrambling, encoding.
// - PRBS bit is XOR of two taps.
// - Each lane PRBS starts at unique phase.
// - Clock pattern: eight ones, eight zeros, raw.
// - Ramp: transport off, link layer encodes.
// - Ramp starts after alignment or serializer init.
// - All lanes same octet ramp, wrapping.
// - Short transport pattern repeats every frame.
// - Link mode 0 word: F-k, k, j.
module stplm_top
    import stplm_pkg::*;
(
    input  wire logic           sys_clk_i,
    input  wire logic           rst_i,
    input  wire stplm_bus_t     bus_i,
    output logic [7:0]          rdata_o,
    input  wire logic           powerdown_pin_i,
    input  wire stplm_samples_t samples_i,
    input  wire logic           ila_done_i,
    input  wire logic           serdes_init_done_i,
    output stplm_lanes_t        lane_data_o,
    output logic [NLANE-1:0]    lane_drv_en_o,
    output logic                core_pd_o,
    output logic [3:0]          ch_pwr_o,
    output logic                link_bypass_o,
    output logic                transport_off_o,
    output logic                sh_fec_o
);
    typedef struct packed {
        logic [1:0]                        pd_sync;
        logic [7:0]                        link_mode;
        logic [3:0]                        test_sel;
        logic                              mode_pd;
        logic [1:0]                        sh_sel;
        logic [1:0]                        ch_pair;
        logic [7:0]                        rdata;
        logic [7:0]                        ramp;
        logic                              ramp_run;
        logic [5:0]                        st_off;
        logic [NLANE-1:0][PRBSW-1:0]       prbs;
        stplm_lanes_t                      lanes;
        logic [NLANE-1:0]                  lane_en;
        logic                              pd;
    } stplm_state_t;

    stplm_state_t s_q;
    stplm_state_t s_d;

    function automatic logic [WW-1:0] pad_word(input stplm_samp_t v);
        return {v, PAD};
    endfunction

    function automatic logic [PRBSW-1:0] prbs_seed(input int lane);
        return SEED_BASE | PRBSW'(lane + 1);
    endfunction

    // State bit 0 is the newest bit; the tap pair is chosen by the pattern length.
    function automatic logic [LW+PRBSW-1:0] prbs_run(input logic [PRBSW-1:0] st, input logic [3:0] sel);
        logic [LW-1:0] out;
        logic          nb;
        int            ta;
        int            tb;
        out = '0;
        nb  = 1'b0;
        case (sel)
            TP_P7:   begin ta = 6;  tb = 7;  end
            TP_P9:   begin ta = 5;  tb = 9;  end
            TP_P15:  begin ta = 14; tb = 15; end
            TP_P23:  begin ta = 18; tb = 23; end
            default: begin ta = 28; tb = 31; end
        endcase
        for (int i = LW - 1; i >= 0; i--) begin
            nb     = st[ta-1] ^ st[tb-1];
            out[i] = nb;
            st     = {st[PRBSW-2:0], nb};
        end
        return {out, st};
    endfunction

    function automatic logic [FW-1:0] short_frame(input int lane);
        logic [FW-1:0] f;
        f = '0;
        for (int j = 1; j <= 5; j++) begin
            f[FW-1-(j-1)*WW -: WW] = {ST_TOP - 4'(lane), 4'(lane), 4'(j)};
        end
        f[3:0] = ST_TAIL;
        return f;
    endfunction

    function automatic logic is_prbs(input logic [3:0] sel);
        return (sel >= TP_P7) && (sel <= TP_P31);
    endfunction

    logic                 pd_now;
    logic                 mode_ok;
    logic                 ramp_start;
    logic [FW*2-1:0]      dbl;
    logic [LW+PRBSW-1:0]  pr;

    always_comb begin
        s_d    = s_q;
        dbl    = '0;
        pr     = '0;
        s_d.pd_sync = {s_q.pd_sync[0], powerdown_pin_i};
        pd_now  = s_q.pd_sync[1] | s_q.mode_pd;
        s_d.pd  = pd_now;
        mode_ok = (s_q.link_mode == LM_ZERO) || (s_q.link_mode == LM_FOUR) || (s_q.link_mode == LM_DUAL);

        // Register writes; power-down never touches these fields.
        if (bus_i.wr) begin
            case (bus_i.addr)
                A_LINK: s_d.link_mode = bus_i.wdata;
                A_TEST: s_d.test_sel = bus_i.wdata[3:0];
                A_CTRL: begin
                    s_d.mode_pd = bus_i.wdata[CTRL_PD];
                    // The three-bit CRC code is not accepted; the old choice stays.
                    if (bus_i.wdata[CTRL_SH +: 2] == SH_CRC12 || bus_i.wdata[CTRL_SH +: 2] == SH_FEC) begin
                        s_d.sh_sel = bus_i.wdata[CTRL_SH +: 2];
                    end
                end
                A_CHEN: begin
                    if (bus_i.wdata[1:0] != CHEN_OFF) begin
                        s_d.ch_pair = bus_i.wdata[1:0];
                    end
                end
                default: ;
            endcase
        end
        s_d.rdata = '0;
        if (bus_i.rd) begin
            case (bus_i.addr)
                A_LINK:  s_d.rdata = s_q.link_mode;
                A_TEST:  s_d.rdata = {4'h0, s_q.test_sel};
                A_CTRL:  s_d.rdata = {5'h00, s_q.sh_sel, s_q.mode_pd};
                A_CHEN:  s_d.rdata = {6'h00, s_q.ch_pair};
                A_STAT:  s_d.rdata = {5'h00, mode_ok, s_q.ramp_run, s_q.pd};
                default: s_d.rdata = '0;
            endcase
        end

        // Lane count follows the link mode in every test mode.
        s_d.lane_en = (mode_ok && !pd_now) ? '1 : '0;

        // Ramp waits for alignment in 8B/10B and serializer init in 64B/66B.
        ramp_start = (s_q.link_mode == LM_ZERO) ? ila_done_i : serdes_init_done_i;
        if (s_q.test_sel != TP_RAMP || pd_now) begin
            s_d.ramp_run = 1'b0;
            s_d.ramp     = '0;
        end else if (s_q.ramp_run) begin
            s_d.ramp = s_q.ramp + RAMP_INC;
        end else if (ramp_start) begin
            s_d.ramp_run = 1'b1;
        end

        s_d.st_off = (s_q.test_sel == TP_SHORT) ? s_q.st_off + ST_STEP : '0;

        for (int k = 0; k < NLANE; k++) begin
            s_d.lanes[k] = '0;
            if (is_prbs(s_q.test_sel)) begin
                pr = prbs_run(s_q.prbs[k], s_q.test_sel);
                s_d.lanes[k] = pr[LW+PRBSW-1 -: LW];
                s_d.prbs[k]  = pr[PRBSW-1:0];
            end else begin
                s_d.prbs[k] = prbs_seed(k);
                case (s_q.test_sel)
                    TP_CLK:   s_d.lanes[k] = {3{CLK_GRP}};
                    TP_RAMP: begin
                        for (int o = 0; o < LW / 8; o++) begin
                            s_d.lanes[k][LW-1-o*8 -: 8] = s_q.ramp_run ? s_q.ramp + 8'(o) : '0;
                        end
                    end
                    TP_SHORT: begin
                        dbl = {short_frame(k), short_frame(k)};
                        s_d.lanes[k] = dbl[FW*2-1-int'(s_q.st_off) -: LW];
                    end
                    default: begin
                        for (int w = 0; w < NWORD; w++) begin
                            if (s_q.link_mode == LM_FOUR) begin
                                s_d.lanes[k][LW-1-w*WW -: WW] =
                                    pad_word(samples_i[(k/2)*8 + 2*w + (k%2)]);
                            end else if (s_q.link_mode == LM_DUAL) begin
                                s_d.lanes[k][LW-1-w*WW -: WW] =
                                    pad_word(samples_i[(k/4)*16 + 4*w + (k%4)]);
                            end
                        end
                    end
                endcase
            end
            if (pd_now || !mode_ok) begin
                s_d.lanes[k] = '0;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_q           <= '0;
            s_q.link_mode <= RST_LINK;
            s_q.test_sel  <= TP_OFF;
            s_q.sh_sel    <= SH_CRC12;
            s_q.ch_pair   <= RST_CHEN;
            for (int k = 0; k < NLANE; k++) begin
                s_q.prbs[k] <= prbs_seed(k);
            end
        end else begin
            s_q <= s_d;
        end
    end

    // The receiver must relink and drop pipeline data after leaving power-down.
    assign core_pd_o       = s_q.pd;
    assign lane_drv_en_o   = s_q.lane_en;
    assign lane_data_o     = s_q.lanes;
    assign rdata_o         = s_q.rdata;
    assign ch_pwr_o        = s_q.pd ? 4'h0 : {{2{s_q.ch_pair[1]}}, {2{s_q.ch_pair[0]}}};
    assign link_bypass_o   = is_prbs(s_q.test_sel) || (s_q.test_sel == TP_CLK);
    assign transport_off_o = (s_q.test_sel != TP_OFF);
    assign sh_fec_o        = (s_q.sh_sel == SH_FEC);
endmodule

/* design/stplm_pkg.sv */
// Purpose: Shared constants and carriers for the lane mapping and test pattern block.
// Assumes: Eight lanes, 48-bit parallel lane words, 9-bit samples.
// Notes: Word 0 of a lane occupies the most significant bits and is sent first.
package stplm_pkg;
    localparam int NLANE  = 8;
    localparam int NSAMP  = 32;
    localparam int SW     = 9;
    localparam int WW     = 12;
    localparam int NWORD  = 4;
    localparam int LW     = 48;
    localparam int FW     = 64;
    localparam int PRBSW  = 31;

    typedef logic [SW-1:0]                  stplm_samp_t;
    typedef stplm_samp_t [NSAMP-1:0]        stplm_samples_t;
    typedef logic [NLANE-1:0][LW-1:0]       stplm_lanes_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } stplm_bus_t;

    // Register addresses.
    localparam logic [3:0] A_LINK   = 4'h0;
    localparam logic [3:0] A_TEST   = 4'h1;
    localparam logic [3:0] A_CTRL   = 4'h2;
    localparam logic [3:0] A_CHEN   = 4'h3;
    localparam logic [3:0] A_STAT   = 4'h4;

    // Control register fields.
    localparam int CTRL_PD  = 0;
    localparam int CTRL_SH  = 1;

    // Link modes.
    localparam logic [7:0] LM_ZERO  = 8'h00;
    localparam logic [7:0] LM_FOUR  = 8'h0E;
    localparam logic [7:0] LM_DUAL  = 8'h0F;

    // Sync header stream use.
    localparam logic [1:0] SH_CRC12 = 2'h0;
    localparam logic [1:0] SH_FEC   = 2'h1;

    // Test pattern select codes.
    localparam logic [3:0] TP_OFF   = 4'h0;
    localparam logic [3:0] TP_P7    = 4'h1;
    localparam logic [3:0] TP_P9    = 4'h2;
    localparam logic [3:0] TP_P15   = 4'h3;
    localparam logic [3:0] TP_P23   = 4'h4;
    localparam logic [3:0] TP_P31   = 4'h5;
    localparam logic [3:0] TP_CLK   = 4'h6;
    localparam logic [3:0] TP_RAMP  = 4'h7;
    localparam logic [3:0] TP_SHORT = 4'h8;

    // Reset values and the refused channel enable code.
    localparam logic [7:0] RST_LINK = LM_FOUR;
    localparam logic [1:0] RST_CHEN = 2'h3;
    localparam logic [1:0] CHEN_OFF = 2'h0;

    // Pattern constants.
    localparam logic [2:0]  PAD      = 3'h0;
    localparam logic [15:0] CLK_GRP  = 16'hFF00;
    localparam logic [7:0]  RAMP_INC = 8'h06;
    localparam logic [3:0]  ST_TOP   = 4'hF;
    localparam logic [3:0]  ST_TAIL  = 4'h0;
    localparam logic [5:0]  ST_STEP  = 6'h30;
    localparam logic [PRBSW-1:0] SEED_BASE = 31'h2AAA_AA80;
endpackage

/* tb/stplm_rx_model.sv */
// Purpose: Receiver model that brings the link up after the lanes start.
// Assumes: Serializer init takes INIT_DLY cycles of steady lane drive.
// Notes: Loss of all lanes restarts bring-up.
`timescale 1ns/1ps
module stplm_rx_model
    import stplm_pkg::*;
#(
    parameter int INIT_DLY = 8
)
(
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic [NLANE-1:0] lane_drv_en_i,
    output logic                  init_done_o
);
    int cnt_q;
    // Old data is never trusted after a drop, so bring-up starts over.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || lane_drv_en_i == '0) begin
            cnt_q <= 0;
        end else if (cnt_q < INIT_DLY) begin
            cnt_q <= cnt_q + 1;
        end
    end
    assign init_done_o = (cnt_q == INIT_DLY);
endmodule

/* tb/stplm_asserts.sv */
// Purpose: Port-level checker for power-down, sync header and mode outputs.
// Assumes: Bound to the top module.
// Notes: Lane content is judged by the bench.
`timescale 1ns/1ps
module stplm_checker
    import stplm_pkg::*;
(
    input wire logic             sys_clk_i,
    input wire logic             rst_i,
    input wire stplm_bus_t       bus_i,
    input wire logic             powerdown_pin_i,
    input wire stplm_lanes_t     lane_data_o,
    input wire logic [NLANE-1:0] lane_drv_en_o,
    input wire logic             core_pd_o,
    input wire logic [3:0]       ch_pwr_o,
    input wire logic             link_bypass_o,
    input wire logic             transport_off_o,
    input wire logic             sh_fec_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_pin_held;
        powerdown_pin_i [*3];
    endsequence
    sequence s_ctrl_wr;
        bus_i.wr && bus_i.addr == A_CTRL;
    endsequence
    pin_pd_a: assert property (s_pin_held |=> core_pd_o) else $error("pin high but awake");
    ctrl_pd_a: assert property (s_ctrl_wr ##0 bus_i.wdata[CTRL_PD] |-> ##2 core_pd_o)
        else $error("mode power-down ignored");
    fec_sel_a: assert property (s_ctrl_wr ##0 bus_i.wdata[2:1] == SH_FEC |=> sh_fec_o)
        else $error("fec not selected");
    crc_sel_a: assert property (s_ctrl_wr ##0 bus_i.wdata[2:1] == SH_CRC12 |=> !sh_fec_o)
        else $error("crc not selected");
    sh_refuse_a: assert property (s_ctrl_wr ##0 bus_i.wdata[2] |=> $stable(sh_fec_o))
        else $error("bad header code taken");
    pd_lanes_a: assert property (core_pd_o |-> lane_drv_en_o == '0 && lane_data_o == '0)
        else $error("lanes live in power-down");
    pd_chpwr_a: assert property (core_pd_o == (ch_pwr_o == 4'h0))
        else $error("channel power wrong");
    bypass_only_a: assert property (link_bypass_o |-> transport_off_o)
        else $error("bypass without test mode");
    lanes_follow_a: assert property ($changed(transport_off_o) && !core_pd_o |=> $stable(lane_drv_en_o))
        else $error("test select moved lanes");
endmodule
bind stplm_top stplm_checker u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_i(bus_i),
    .powerdown_pin_i(powerdown_pin_i), .lane_data_o(lane_data_o), .lane_drv_en_o(lane_drv_en_o),
    .core_pd_o(core_pd_o), .ch_pwr_o(ch_pwr_o), .link_bypass_o(link_bypass_o),
    .transport_off_o(transport_off_o), .sh_fec_o(sh_fec_o));

/* tb/tb.sv */
// Purpose: Self-checking bench for lane mapping and test patterns.
// Assumes: Receiver model drives both start inputs.
// Notes: Outputs are read 1 ns after an edge.
`timescale 1ns/1ps
module tb;
    import stplm_pkg::*;
    logic           sys_clk_i, rst_i, pin, init, pd, byp, toff, fec, bad;
    stplm_bus_t     bus;
    stplm_samples_t smp;
    stplm_lanes_t   lanes;
    logic [7:0]     rdata, drv;
    logic [3:0]     chp;
    logic [95:0]    acc;
    logic [191:0]   sa [NLANE];
    int             bad_count, total_checks;
    int             tap_a [5] = '{6, 5, 14, 18, 28};
    int             tap_b [5] = '{7, 9, 15, 23, 31};
    stplm_top u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
        .powerdown_pin_i(pin), .samples_i(smp), .ila_done_i(init), .serdes_init_done_i(init),
        .lane_data_o(lanes), .lane_drv_en_o(drv), .core_pd_o(pd), .ch_pwr_o(chp),
        .link_bypass_o(byp), .transport_off_o(toff), .sh_fec_o(fec));
    stplm_rx_model u_rx (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .lane_drv_en_i(drv), .init_done_o(init));
    task automatic chk(input logic [191:0] s, input logic [191:0] e);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value at %0t: %h not %h", $time, s, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk_i);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk_i);
        bus.rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    function automatic logic [47:0] emap(int k, bit dual);
        logic [47:0] e;
        int          ix;
        for (int w = 0; w < NWORD; w++) begin
            ix = dual ? (k / 4) * 16 + 4 * w + k % 4 : (k / 2) * 8 + 2 * w + k % 2;
            e[47 - WW * w -: WW] = {smp[ix], PAD};
        end
        return e;
    endfunction
    function automatic logic [63:0] sframe(int k);
        logic [63:0] f;
        for (int j = 1; j < 6; j++) f[75 - WW * j -: WW] = {ST_TOP - 4'(k), 4'(k), 4'(j)};
        f[3:0] = ST_TAIL;
        return f;
    endfunction
    function automatic logic [47:0] rmp(logic [7:0] r);
        logic [47:0] o;
        for (int i = 0; i < 6; i++) o[47 - 8 * i -: 8] = r + 8'(i);
        return o;
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        #100000;
        bad_count++;
        conclude();
    end
    initial begin
        bus = '0;
        pin = 1'b0;
        rst_i = 1'b1;
        for (int i = 0; i < NSAMP; i++) smp[i] = 9'(i * 37 + 5);
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd(A_LINK, RST_LINK);
        rd(A_CHEN, {6'h00, RST_CHEN});
        rd(4'hF, 8'h00);
        chk(chp, 4'hF);
        wr(A_LINK, 8'h05);
        tick(2);
        chk({drv, lanes[0]}, 56'h0);
        rd(A_STAT, 8'h00);
        for (int m = 0; m < 2; m++) begin
            wr(A_LINK, m ? LM_DUAL : LM_FOUR);
            tick(3);
            for (int k = 0; k < NLANE; k++) chk(lanes[k], emap(k, m));
            chk(drv, 8'hFF);
        end
        rd(A_STAT, 8'h04);
        $display("mapping test done");
        for (int i = 0; i < 4; i++) begin
            wr(A_CTRL, {5'h00, 2'(i + 1), 1'b0});
            tick(1);
            chk(fec, i < 3);
        end
        wr(A_CHEN, 8'h00);
        rd(A_CHEN, 8'h03);
        wr(A_CHEN, 8'h01);
        tick(1);
        chk(chp, 4'h3);
        $display("control test done");
        wr(A_TEST, TP_CLK);
        tick(3);
        for (int k = 0; k < NLANE; k++) chk(lanes[k], {3{CLK_GRP}});
        chk({byp, toff, drv}, 10'h3FF);
        for (int p = 0; p < 5; p++) begin
            wr(A_TEST, TP_P7 + 4'(p));
            tick(3);
            acc[95:48] = lanes[0];
            tick(1);
            acc[47:0] = lanes[0];
            bad = 1'b0;
            for (int n = 31; n < 96; n++) bad |= acc[95 - n] ^ acc[95 - n + tap_a[p]] ^ acc[95 - n + tap_b[p]];
            chk(bad, 1'b0);
            chk(lanes[0] === lanes[1], 1'b0);
            chk(byp, 1'b1);
        end
        $display("prbs test done");
        wr(A_TEST, TP_SHORT);
        tick(2);
        for (int i = 0; i < 4 && lanes[0][47:36] !== 12'hF01; i++) tick(1);
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < NLANE; k++) sa[k] = {sa[k][143:0], lanes[k]};
            tick(1);
        end
        for (int k = 0; k < NLANE; k++) chk(sa[k], {3{sframe(k)}});
        wr(A_CTRL, 8'h01);
        tick(2);
        chk({pd, drv}, 9'h100);
        wr(A_TEST, TP_RAMP);
        tick(2);
        chk({byp, toff}, 2'b01);
        wr(A_CTRL, 8'h00);
        pin <= 1'b1;
        tick(4);
        chk({pd, drv, chp}, 13'h1000);
        rd(A_LINK, LM_DUAL);
        rd(A_TEST, {4'h0, TP_RAMP});
        @(posedge sys_clk_i);
        pin <= 1'b0;
        for (int i = 0; i < 40 && lanes[0] === 48'h0; i++) tick(1);
        chk(init, 1'b1);
        for (int c = 0; c < 44; c++) begin
            for (int k = 0; k < NLANE; k++) chk(lanes[k], rmp(8'(6 * c)));
            tick(1);
        end
        $display("pattern test done");
        conclude();
    end
endmodule
